// [include/apsp_consts.svh]
// apsp_consts.svh: offsets, command codes, field positions, reset values, pulse timing
// assumes: included by bare name from the package, apsp_top and the checker apsp_top_chk
`ifndef APSP_CONSTS_SVH
`define APSP_CONSTS_SVH

`define APSP_AXES 4
`define APSP_PINS 8
`define APSP_ADDR_W 8
`define APSP_DATA_W 16

// register word addresses on the plain register port
`define APSP_OFS_DATA 8'h00
`define APSP_OFS_CMD 8'h01
`define APSP_OFS_MAIN_STATUS 8'h02
`define APSP_OFS_INPUT_A 8'h04
`define APSP_OFS_INPUT_B 8'h05
`define APSP_OFS_OUTPUT_A 8'h06
`define APSP_OFS_OUTPUT_B 8'h07
`define APSP_OFS_IRQ_STATUS 8'h08
`define APSP_OFS_IRQ_MASK 8'h09
`define APSP_OFS_THIRD_STATUS 8'h10
`define APSP_OFS_PIN_FUNC 8'h20
`define APSP_OFS_SECOND 8'h24

// command register fields and codes
`define APSP_CMD_CODE_LSB 0
`define APSP_CMD_AXIS_LSB 8
`define APSP_CMD_PIN_FUNC 8'h21
`define APSP_CMD_SECOND 8'h22
`define APSP_CMD_ERR_CLR 8'h79

// secondary setting register fields
`define APSP_SS_POL_LSB 0
`define APSP_SS_PW_LSB 4
`define APSP_SS_ERROR_DISABLES_SYNC_ACTIONS_BIT 7
`define APSP_SS_EXOP_LSB 8
`define APSP_SS_SPLIT_PULSE_POLARITY_BIT 10
`define APSP_SS_SPLIT_PULSE_START_PULSE_BIT 11
`define APSP_SS_USED_MSB 11

// main status / third status fields
`define APSP_MS_ERR_LSB 4
`define APSP_TS_ERR_BIT 4

`define APSP_PIN_FUNC_RST 16'h0000
`define APSP_SECOND_RST 12'h000

// sync pulse widths, in ns as printed, at the reference clock
`define APSP_REF_MHZ 16
`define APSP_PW0_NS 125
`define APSP_PW1_NS 312
`define APSP_PW2_NS 1000
`define APSP_PW3_NS 4000
`define APSP_PW4_NS 16000
`define APSP_PW5_NS 64000
`define APSP_PW6_NS 256000
`define APSP_PW7_NS 1000000
`define APSP_NS2CYC(ns) (((ns) * `APSP_REF_MHZ + 999) / 1000)
`define APSP_PW0_CYC `APSP_NS2CYC(`APSP_PW0_NS)
`define APSP_PW1_CYC `APSP_NS2CYC(`APSP_PW1_NS)
`define APSP_PW2_CYC `APSP_NS2CYC(`APSP_PW2_NS)
`define APSP_PW3_CYC `APSP_NS2CYC(`APSP_PW3_NS)
`define APSP_PW4_CYC `APSP_NS2CYC(`APSP_PW4_NS)
`define APSP_PW5_CYC `APSP_NS2CYC(`APSP_PW5_NS)
`define APSP_PW6_CYC `APSP_NS2CYC(`APSP_PW6_NS)
`define APSP_PW7_CYC `APSP_NS2CYC(`APSP_PW7_NS)

`endif

// [include/apsp_pkg.sv]
// apsp_pkg: types shared by the axis pin configuration block
// assumes: apsp_consts.svh on the include path
`include "apsp_consts.svh"
package apsp_pkg;
   typedef enum logic [1:0] {
      APSP_FN_INPUT,
      APSP_FN_OUTPUT,
      APSP_FN_STATUS,
      APSP_FN_SYNC
   } apsp_pin_func_t;

   typedef enum logic [1:0] {
      APSP_EXT_OFF,
      APSP_EXT_CONTINUOUS,
      APSP_EXT_RELATIVE,
      APSP_EXT_PULSER
   } apsp_ext_mode_t;

   typedef logic [`APSP_DATA_W-1:0] apsp_word_t;
endpackage

// [verilog/apsp_pulse_gen.sv]
// apsp_pulse_gen: one-shot pulse of a programmed number of clock cycles
// assumes: fire_in is a one-cycle request on sys_clk_in; width is at least one
`timescale 1ns/1ps
module apsp_pulse_gen #(
   parameter int CNT_W = 17
) (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic fire_in,
   input wire logic [CNT_W-1:0] width_cyc_in,
   output logic active_out
);
   import apsp_pkg::*;

   logic [CNT_W-1:0] left_q;

   // a new request while active restarts the width, so pulses merge
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         left_q <= '0;
      end else if (fire_in) begin
         left_q <= width_cyc_in;
      end else if (left_q != '0) begin
         left_q <= left_q - 1'b1;
      end
   end

   assign active_out = (left_q != '0);
endmodule

// [verilog/apsp_top.sv]
// apsp_top: per-axis multi-purpose pin functions and secondary settings
// assumes: four axes of eight pins, inputs synchronous to sys_clk_in,
// action engine, comparators and drive sequencer sit outside this block
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "apsp_consts.svh"
module apsp_top #(
   parameter int CNT_W = 17,
   parameter int LONGEST_PULSE_CYC = `APSP_PW7_CYC
) (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic [`APSP_ADDR_W-1:0] reg_addr_in,
   input wire apsp_pkg::apsp_word_t reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output apsp_pkg::apsp_word_t reg_rdata_out,
   input wire logic [31:0] pin_in,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe_n_out,
   input wire logic [31:0] drive_status_in,
   input wire logic [15:0] cmp_result_in,
   input wire logic [15:0] sync_pulse_req_in,
   input wire logic [3:0] axis_error_in,
   output logic [15:0] sync_action_enable_out,
   output logic [31:0] sync_trigger_level_out,
   output logic [3:0] external_plus_drive_out,
   output logic [3:0] external_minus_drive_out,
   output logic [7:0] external_drive_mode_select_out,
   output logic [3:0] split_pulse_polarity_out,
   output logic [3:0] split_pulse_start_pulse_out,
   output logic irq_out
);
   import apsp_pkg::*;

   localparam int AXES = `APSP_AXES;
   localparam int PINS = `APSP_PINS;
   localparam logic [CNT_W-1:0] PW0 = CNT_W'(`APSP_PW0_CYC);
   localparam logic [CNT_W-1:0] PW1 = CNT_W'(`APSP_PW1_CYC);
   localparam logic [CNT_W-1:0] PW2 = CNT_W'(`APSP_PW2_CYC);
   localparam logic [CNT_W-1:0] PW3 = CNT_W'(`APSP_PW3_CYC);
   localparam logic [CNT_W-1:0] PW4 = CNT_W'(`APSP_PW4_CYC);
   localparam logic [CNT_W-1:0] PW5 = CNT_W'(`APSP_PW5_CYC);
   localparam logic [CNT_W-1:0] PW6 = CNT_W'(`APSP_PW6_CYC);
   localparam logic [CNT_W-1:0] PW7 = CNT_W'(LONGEST_PULSE_CYC);

   // widths follow the clock, not absolute time
   function automatic logic [CNT_W-1:0] width_cycles(input logic [2:0] code);
      logic [CNT_W-1:0] w;
      w = PW0;
      unique case (code)
         3'h0: w = PW0;
         3'h1: w = PW1;
         3'h2: w = PW2;
         3'h3: w = PW3;
         3'h4: w = PW4;
         3'h5: w = PW5;
         3'h6: w = PW6;
         3'h7: w = PW7;
      endcase
      return w;
   endfunction

   logic wr_data;
   logic wr_cmd;
   logic [7:0] cmd_code;
   logic [3:0] cmd_axes;
   logic rd_irq;

   apsp_word_t data_q;
   apsp_word_t pin_func_q [AXES];
   logic [`APSP_SS_USED_MSB:0] second_q [AXES];
   logic [31:0] out_val_q;
   logic [3:0] err_q;
   logic [3:0] err_d;
   logic [3:0] err_rise;
   logic [3:0] sync_en_q [AXES];
   logic [3:0] autodis;
   logic [7:0] irq_st_q;
   logic [7:0] irq_st_d;
   logic [7:0] irq_mask_q;
   logic [15:0] pulse_active;
   apsp_word_t rdata_d;

   assign wr_data = reg_wr_in && (reg_addr_in == `APSP_OFS_DATA);
   assign wr_cmd = reg_wr_in && (reg_addr_in == `APSP_OFS_CMD);
   assign cmd_code = reg_wdata_in[`APSP_CMD_CODE_LSB +: 8];
   assign cmd_axes = reg_wdata_in[`APSP_CMD_AXIS_LSB +: 4];
   assign rd_irq = reg_rd_in && (reg_addr_in == `APSP_OFS_IRQ_STATUS);

   // parameter word staged before a command moves it into an axis
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         data_q <= '0;
      end else if (wr_data) begin
         data_q <= reg_wdata_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         out_val_q <= '0;
      end else if (reg_wr_in && reg_addr_in == `APSP_OFS_OUTPUT_A) begin
         out_val_q[15:0] <= reg_wdata_in;
      end else if (reg_wr_in && reg_addr_in == `APSP_OFS_OUTPUT_B) begin
         out_val_q[31:16] <= reg_wdata_in;
      end
   end

   // error flag: new error wins over a clear in the same cycle
   assign err_rise = axis_error_in & ~err_q;
   always_comb begin
      err_d = err_q;
      if (wr_cmd && cmd_code == `APSP_CMD_ERR_CLR) begin
         err_d = err_d & ~cmd_axes;
      end
      err_d = err_d | axis_error_in;
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         err_q <= '0;
      end else begin
         err_q <= err_d;
      end
   end

   genvar a;
   generate
      for (a = 0; a < AXES; a++) begin : g_axis
         logic wr_sync_en;

         // pin function (cmd 21h) and secondary setting (cmd 22h)
         always_ff @(posedge sys_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               pin_func_q[a] <= `APSP_PIN_FUNC_RST;
               second_q[a] <= `APSP_SECOND_RST;
            end else if (wr_cmd && cmd_axes[a]) begin
               if (cmd_code == `APSP_CMD_PIN_FUNC) begin
                  pin_func_q[a] <= data_q;
               end
               // upper bits are not stored; host keeps them zero
               if (cmd_code == `APSP_CMD_SECOND) begin
                  second_q[a] <= data_q[`APSP_SS_USED_MSB:0];
               end
            end
         end

         assign autodis[a] = err_rise[a] && second_q[a][`APSP_SS_ERROR_DISABLES_SYNC_ACTIONS_BIT];
         assign wr_sync_en = reg_wr_in &&
            (reg_addr_in == `APSP_OFS_THIRD_STATUS + 8'(a));

         // error-disable beats a same-cycle enable write
         always_ff @(posedge sys_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               sync_en_q[a] <= '0;
            end else if (autodis[a]) begin
               sync_en_q[a] <= '0;
            end else if (wr_sync_en) begin
               // while flagged, only disabling bits take effect
               sync_en_q[a] <= err_q[a] ? (sync_en_q[a] & reg_wdata_in[3:0]) :
                  reg_wdata_in[3:0];
            end
         end

         // config fields handed to the outside engines
         always_ff @(posedge sys_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               sync_action_enable_out[4*a +: 4] <= '0;
               external_drive_mode_select_out[2*a +: 2] <= APSP_EXT_OFF;
               split_pulse_polarity_out[a] <= 1'b0;
               split_pulse_start_pulse_out[a] <= 1'b0;
               external_plus_drive_out[a] <= 1'b0;
               external_minus_drive_out[a] <= 1'b0;
            end else begin
               sync_action_enable_out[4*a +: 4] <= sync_en_q[a];
               external_drive_mode_select_out[2*a +: 2] <=
                  second_q[a][`APSP_SS_EXOP_LSB +: 2];
               split_pulse_polarity_out[a] <= second_q[a][`APSP_SS_SPLIT_PULSE_POLARITY_BIT];
               split_pulse_start_pulse_out[a] <= second_q[a][`APSP_SS_SPLIT_PULSE_START_PULSE_BIT];
               // request only with input mode and a drive mode chosen
               external_plus_drive_out[a] <= pin_in[PINS*a + 4] &&
                  (pin_func_q[a][9:8] == APSP_FN_INPUT) &&
                  (second_q[a][`APSP_SS_EXOP_LSB +: 2] != APSP_EXT_OFF);
               external_minus_drive_out[a] <= pin_in[PINS*a + 5] &&
                  (pin_func_q[a][11:10] == APSP_FN_INPUT) &&
                  (second_q[a][`APSP_SS_EXOP_LSB +: 2] != APSP_EXT_OFF);
            end
         end

         genvar m;
         for (m = 0; m < PINS; m++) begin : g_pin
            localparam int P = PINS * a + m;
            apsp_pin_func_t fn;
            logic drv_val;
            logic drv_oe_n;

            assign fn = apsp_pin_func_t'(pin_func_q[a][2*m +: 2]);

            if (m < 4) begin : g_sync
               apsp_pulse_gen #(
                  .CNT_W(CNT_W)
               ) u_pulse (
                  .sys_clk_in(sys_clk_in),
                  .resetn_in(resetn_in),
                  .fire_in(sync_pulse_req_in[4*a + m]),
                  .width_cyc_in(width_cycles(second_q[a][`APSP_SS_PW_LSB +: 3])),
                  .active_out(pulse_active[4*a + m])
               );
            end

            // role per function code
            always_comb begin
               drv_val = 1'b0;
               drv_oe_n = 1'b0;
               unique case (fn)
                  APSP_FN_INPUT: drv_oe_n = 1'b1;
                  APSP_FN_OUTPUT: drv_val = out_val_q[P];
                  APSP_FN_STATUS: drv_val = drive_status_in[P];
                  APSP_FN_SYNC: begin
                     // lower pins pulse, upper pins compare
                     if (m < 4) begin
                        drv_val = pulse_active[4*a + (m % 4)] ^
                           second_q[a][`APSP_SS_POL_LSB + (m % 4)];
                     end else begin
                        drv_val = cmp_result_in[4*a + (m % 4)];
                     end
                  end
               endcase
            end

            always_ff @(posedge sys_clk_in or negedge resetn_in) begin
               if (!resetn_in) begin
                  pin_out[P] <= 1'b0;
                  pin_oe_n_out[P] <= 1'b1;
                  sync_trigger_level_out[P] <= 1'b0;
               end else begin
                  pin_out[P] <= drv_val;
                  pin_oe_n_out[P] <= drv_oe_n;
                  // only input-mode pins may trigger actions
                  sync_trigger_level_out[P] <= (fn == APSP_FN_INPUT) && pin_in[P];
               end
            end
         end
      end
   endgenerate

   // interrupt: [3:0] error raised, [7:4] actions auto-disabled
   always_comb begin
      irq_st_d = irq_st_q;
      if (rd_irq) begin
         irq_st_d = '0;
      end
      irq_st_d = irq_st_d | {autodis, err_rise};
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_st_q <= '0;
         irq_mask_q <= '0;
         irq_out <= 1'b0;
      end else begin
         irq_st_q <= irq_st_d;
         if (reg_wr_in && reg_addr_in == `APSP_OFS_IRQ_MASK) begin
            irq_mask_q <= reg_wdata_in[7:0];
         end
         irq_out <= |(irq_st_d & irq_mask_q);
      end
   end

   // read mux; unmapped addresses return zero
   always_comb begin
      rdata_d = '0;
      if (reg_addr_in == `APSP_OFS_DATA) begin
         rdata_d = data_q;
      end else if (reg_addr_in == `APSP_OFS_MAIN_STATUS) begin
         rdata_d[`APSP_MS_ERR_LSB +: 4] = err_q;
      end else if (reg_addr_in == `APSP_OFS_INPUT_A) begin
         rdata_d = pin_in[15:0];
      end else if (reg_addr_in == `APSP_OFS_INPUT_B) begin
         rdata_d = pin_in[31:16];
      end else if (reg_addr_in == `APSP_OFS_OUTPUT_A) begin
         rdata_d = out_val_q[15:0];
      end else if (reg_addr_in == `APSP_OFS_OUTPUT_B) begin
         rdata_d = out_val_q[31:16];
      end else if (reg_addr_in == `APSP_OFS_IRQ_STATUS) begin
         rdata_d[7:0] = irq_st_q;
      end else if (reg_addr_in == `APSP_OFS_IRQ_MASK) begin
         rdata_d[7:0] = irq_mask_q;
      end
      for (int i = 0; i < AXES; i++) begin
         if (reg_addr_in == `APSP_OFS_THIRD_STATUS + 8'(i)) begin
            rdata_d[3:0] = sync_en_q[i];
            rdata_d[`APSP_TS_ERR_BIT] = err_q[i];
         end
         if (reg_addr_in == `APSP_OFS_PIN_FUNC + 8'(i)) begin
            rdata_d = pin_func_q[i];
         end
         if (reg_addr_in == `APSP_OFS_SECOND + 8'(i)) begin
            rdata_d[`APSP_SS_USED_MSB:0] = second_q[i];
         end
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= '0;
      end else begin
         reg_rdata_out <= reg_rd_in ? rdata_d : '0;
      end
   end
endmodule

// [tb/apsp_top_chk.sv]
// apsp_top_chk: port-level checks on the axis pin block
// assumes: bound into apsp_top, one clock, asynchronous active-low reset
`timescale 1ns/1ps
`include "apsp_consts.svh"
module apsp_top_chk (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic [`APSP_ADDR_W-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire apsp_pkg::apsp_word_t reg_rdata_out,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_oe_n_out,
   input wire logic [3:0] axis_error_in,
   input wire logic [15:0] sync_action_enable_out,
   input wire logic [31:0] sync_trigger_level_out,
   input wire logic [3:0] external_plus_drive_out,
   input wire logic [3:0] external_minus_drive_out,
   input wire logic [7:0] external_drive_mode_select_out,
   input wire logic [3:0] split_pulse_polarity_out,
   input wire logic [3:0] split_pulse_start_pulse_out,
   input wire logic irq_out
);
   import apsp_pkg::*;
   logic cmd_wr;
   logic en_wr;
   logic mask_wr;
   assign cmd_wr = reg_wr_in && reg_addr_in == `APSP_OFS_CMD;
   assign en_wr = reg_wr_in && reg_addr_in[7:2] == 6'h04;
   assign mask_wr = reg_wr_in && reg_addr_in == `APSP_OFS_IRQ_MASK;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!resetn_in);

   property p_rd_idle;
      !$past(reg_rd_in) || $past(reg_addr_in) == 8'hFF |-> reg_rdata_out == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_mode_hold;
      $stable(external_drive_mode_select_out) || $past(cmd_wr) || $past(cmd_wr, 2);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved without command");
   property p_split_hold;
      $stable({split_pulse_polarity_out, split_pulse_start_pulse_out})
         || $past(cmd_wr) || $past(cmd_wr, 2);
   endproperty
   a_split_hold: assert property (p_split_hold) else $error("split bits moved");
   property p_ext_gate;
      external_drive_mode_select_out == 8'h00 && $past(external_drive_mode_select_out) == 8'h00
         |-> (external_plus_drive_out | external_minus_drive_out) == 4'h0;
   endproperty
   a_ext_gate: assert property (p_ext_gate) else $error("external drive while disabled");
   property p_oe_hold;
      $stable(pin_oe_n_out) || $past(cmd_wr) || $past(cmd_wr, 2);
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("pin direction moved");
   property p_en_rise;
      (sync_action_enable_out & ~$past(sync_action_enable_out)) != 16'h0000
         |-> $past(en_wr) || $past(en_wr, 2);
   endproperty
   a_en_rise: assert property (p_en_rise) else $error("enable rose without write");
   property p_trig;
      sync_trigger_level_out == ($past(pin_in) & pin_oe_n_out);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger level wrong");
   property p_irq_rise;
      $rose(irq_out) |-> $past(axis_error_in) != 4'h0 || $past(axis_error_in, 2) != 4'h0
         || $past(axis_error_in, 3) != 4'h0 || $past(mask_wr) || $past(mask_wr, 2);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
endmodule
bind apsp_top apsp_top_chk chk_u (.*);

// [tb/apsp_far_side.sv]
// apsp_far_side: sensors and drivers seen on the axis pins
// assumes: a released pin carries the sensor level, a driven one reads back
`timescale 1ns/1ps
module apsp_far_side (
   input wire logic [31:0] pin_out_in,
   input wire logic [31:0] pin_oe_n_in,
   input wire logic [31:0] sensor_in,
   output logic [31:0] pin_level_out
);
   assign pin_level_out = (pin_oe_n_in & sensor_in) | (~pin_oe_n_in & pin_out_in);
endmodule

// [tb/test_axis_pio_and_sync_pulse_config.sv]
// test_axis_pio_and_sync_pulse_config: self-checking bench for apsp_top
// assumes: far side in apsp_far_side.sv, checker bound from apsp_top_chk.sv
`timescale 1ns/1ps
module test_axis_pio_and_sync_pulse_config;
   import apsp_pkg::*;
   localparam int LP = 20;
   logic sys_clk, resetn, wr, rd, irq;
   logic [7:0] addr, mode;
   apsp_word_t wdata, rdata;
   logic [31:0] pin_in, pin_out, oe_n, dstat, trig, pat, outv;
   logic [15:0] cmp, sreq, en_out, v;
   logic [15:0] sec[4], fn[4];
   logic [3:0] aerr, ep, em, spol, sst;
   int fails = 0, n_tests = 0, w, cnt, f, e;
   int ns[8] = '{125, 312, 1000, 4000, 16000, 64000, 256000, 1000000};
   int codes[8] = '{0, 1, 2, 3, 4, 5, 6, 7};

   apsp_top #(.LONGEST_PULSE_CYC(LP)) dut_u (
      .sys_clk_in(sys_clk), .resetn_in(resetn), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n_out(oe_n), .drive_status_in(dstat),
      .cmp_result_in(cmp), .sync_pulse_req_in(sreq), .axis_error_in(aerr),
      .sync_action_enable_out(en_out), .sync_trigger_level_out(trig),
      .external_plus_drive_out(ep), .external_minus_drive_out(em),
      .external_drive_mode_select_out(mode), .split_pulse_polarity_out(spol),
      .split_pulse_start_pulse_out(sst), .irq_out(irq)
   );
   apsp_far_side far_u (.pin_out_in(pin_out), .pin_oe_n_in(oe_n), .sensor_in(pat),
      .pin_level_out(pin_in));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   // data staging then command, axis mask in the command word
   task automatic load(input logic [3:0] msk, input logic [15:0] d, input logic [7:0] code);
      wr_reg(8'h00, d);
      wr_reg(8'h01, {4'h0, msk, code});
   endtask
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   initial begin
      #200000;
      fails++;
      summarize();
   end

   initial begin
      resetn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      dstat = 32'h0;
      cmp = 16'h0;
      sreq = 16'h0;
      aerr = 4'h0;
      pat = 32'h0;
      void'($urandom(32'hFF0D));
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         rchk(8'(8'h20 + a), 16'h0000);
         rchk(8'(8'h24 + a), 16'h0000);
      end
      wr_reg(8'h24, 16'hFFFF);
      wr_reg(8'hFF, 16'hFFFF);
      rchk(8'h24, 16'h0000);
      rchk(8'hFF, 16'h0000);
      $display("test reset done");

      for (int a = 0; a < 4; a++) begin
         // upper nibble kept zero by the host
         sec[a] = 16'(($urandom & 16'h0CFF) | (a << 8));
         load(4'(1 << a), sec[a], 8'h22);
         rchk(8'(8'h24 + a), sec[a]);
      end
      settle();
      for (int a = 0; a < 4; a++) begin
         chk(mode[2*a+:2], sec[a][9:8]);
         chk(spol[a], sec[a][10]);
         chk(sst[a], sec[a][11]);
      end
      $display("test secondary done");

      @(posedge sys_clk);
      pat <= $urandom;
      settle();
      rchk(8'h04, pat[15:0]);
      rchk(8'h05, pat[31:16]);
      chk(trig, pat);
      for (int a = 0; a < 4; a++) begin
         chk(ep[a], sec[a][9:8] != 2'b00 && pat[8*a+4]);
         chk(em[a], sec[a][9:8] != 2'b00 && pat[8*a+5]);
      end
      $display("test inputs done");

      outv = $urandom;
      @(posedge sys_clk);
      dstat <= $urandom;
      cmp <= 16'($urandom);
      wr_reg(8'h06, outv[15:0]);
      wr_reg(8'h07, outv[31:16]);
      for (int a = 0; a < 4; a++) begin
         fn[a] = 16'($urandom);
         load(4'(1 << a), fn[a], 8'h21);
         rchk(8'(8'h20 + a), fn[a]);
      end
      settle();
      for (int p = 0; p < 32; p++) begin
         f = (fn[p/8] >> (2 * (p % 8))) & 3;
         if (f == 1) e = outv[p];
         else if (f == 2) e = dstat[p];
         else if (p % 8 < 4) e = sec[p/8][p%8];
         else e = cmp[4*(p/8)+p%8-4];
         chk(oe_n[p], f == 0);
         if (f != 0) chk(pin_out[p], e);
         chk(trig[p], f == 0 && pat[p]);
      end
      // drive requests only from pins left in input mode
      for (int a = 0; a < 4; a++) begin
         chk(ep[a], fn[a][9:8] == 2'b00 && sec[a][9:8] != 2'b00 && pat[8*a+4]);
         chk(em[a], fn[a][11:10] == 2'b00 && sec[a][9:8] != 2'b00 && pat[8*a+5]);
      end
      $display("test pins done");

      load(4'h1, 16'h00FF, 8'h21);
      foreach (codes[i]) begin
         sec[0] = 16'(codes[i] * 16 + i % 2);
         load(4'h1, sec[0], 8'h22);
         w = codes[i] == 7 ? LP : (ns[codes[i]] * 16 + 999) / 1000;
         @(posedge sys_clk);
         sreq <= 16'h0001;
         @(posedge sys_clk);
         sreq <= 16'h0000;
         cnt = 0;
         repeat (w + 4) begin
            @(posedge sys_clk);
            #1;
            if (pin_out[0] !== sec[0][0]) cnt++;
         end
         chk(cnt, w);
         chk(pin_out[0], sec[0][0]);
      end
      $display("test pulse done");

      load(4'h2, 16'h0080, 8'h22);
      load(4'h4, 16'h0000, 8'h22);
      wr_reg(8'h11, 16'h000F);
      wr_reg(8'h12, 16'h000F);
      @(posedge sys_clk);
      aerr <= 4'h6;
      @(posedge sys_clk);
      aerr <= 4'h0;
      settle();
      chk(en_out, 16'h0F00);
      chk(irq, 1'b0);
      rchk(8'h02, 16'h0060);
      rchk(8'h11, 16'h0010);
      wr_reg(8'h11, 16'h000F);
      rchk(8'h11, 16'h0010);
      wr_reg(8'h09, 16'h00FF);
      settle();
      chk(irq, 1'b1);
      rchk(8'h08, 16'h0026);
      settle();
      chk(irq, 1'b0);
      load(4'h6, 16'h0000, 8'h79);
      rchk(8'h02, 16'h0000);
      wr_reg(8'h11, 16'h000F);
      rchk(8'h11, 16'h000F);
      $display("test error done");
      summarize();
   end
endmodule
